// ===== rtl/bfs_pkg.sv
// constants, register map and types of the bridge fault supervisor
package bfs_pkg;

  // ****************************************
  // clock and fault output timing
  // ****************************************
  localparam int CLK_MHZ        = 200;
  localparam int FAULT_PIN_KHZ  = 625;
  localparam int PWM_PERIOD_CYC = CLK_MHZ * 1000 / FAULT_PIN_KHZ;
  localparam int DUTY_STEPS     = 8;
  localparam int PWM_STEP_CYC   = PWM_PERIOD_CYC / DUTY_STEPS;

  // ****************************************
  // supervision times
  // ****************************************
  localparam int REFRESH_TIME_NS = 900_000;
  localparam int REFRESH_CYC     = (REFRESH_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int OV_TIME_MS      = 400;
  localparam int OV_CYC          = OV_TIME_MS * CLK_MHZ * 1000;
  localparam int MASK_TIME_NS    = 500;
  localparam int MASK_CYC        = (MASK_TIME_NS * CLK_MHZ + 999) / 1000;

  // ****************************************
  // duty codes in eighths of the period
  // ****************************************
  localparam logic [3:0] DUTY_NONE   = 4'h1;
  localparam logic [3:0] DUTY_DS     = 4'h2;
  localparam logic [3:0] DUTY_SUPPLY = 4'h4;
  localparam logic [3:0] DUTY_PINCHK = 4'h5;
  localparam logic [3:0] DUTY_OC     = 4'h6;
  localparam logic [3:0] DUTY_THERM  = 4'h7;
  localparam logic [3:0] DUTY_LOGIC  = 4'h8;

  // ****************************************
  // register map
  // ****************************************
  localparam int         ADDR_W      = 8;
  localparam int         EV_W        = 9;
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_IRQ_EN  = 8'h04;
  localparam logic [7:0] REG_IRQ_CLR = 8'h08;
  localparam logic [7:0] REG_LIVE    = 8'h0C;
  localparam logic [8:0] IRQ_EN_RST  = 9'h000;
  localparam int         LIVE_DUTY_LSB = 16;

  // event bit positions
  localparam int EV_DS    = 0;
  localparam int EV_PUMP  = 1;
  localparam int EV_MOTLO = 2;
  localparam int EV_MOTHI = 3;
  localparam int EV_BOOT  = 4;
  localparam int EV_OC    = 5;
  localparam int EV_THERM = 6;
  localparam int EV_LOGIC = 7;
  localparam int EV_PIN   = 8;

  // gate index order
  localparam int G_HA = 0;
  localparam int G_LA = 1;
  localparam int G_HB = 2;
  localparam int G_LB = 3;
  localparam logic [3:0] LOWS_ONLY = 4'hA;

  typedef enum logic {
    RF_IDLE   = 1'b0,
    RF_ACTIVE = 1'b1
  } bfs_refresh_t;

endpackage

// ===== rtl/bfs_duty_if.sv
// duty code passed from the supervisor to the fault output generator
`timescale 1ns/1ps
`default_nettype none
interface bfs_duty_if;
  logic [3:0] eighths;
  modport src (output eighths);
  modport pwm (input eighths);
endinterface
`default_nettype wire

// ===== rtl/bfs_sync2.sv
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module bfs_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/bfs_duty_pwm.sv
// duty-coded fault output at the fixed pulse rate
`timescale 1ns/1ps
`default_nettype none
module bfs_duty_pwm import bfs_pkg::*; (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // duty code
  bfs_duty_if.pwm   duty,
  // fault pin
  output logic      pulse
);
  localparam int CW = $clog2(PWM_PERIOD_CYC);
  logic [CW-1:0] cnt;
  logic [CW-1:0] limit;

  // eighths * step never passes the period, so it fits the counter width
  assign limit = CW'(duty.eighths) * CW'(PWM_STEP_CYC);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt <= '0;
    end else if (cnt == CW'(PWM_PERIOD_CYC - 1)) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pulse <= 1'b0;
    end else begin
      pulse <= (cnt < limit);
    end
  end

  a_none_high_part: assert property (@(posedge clk) disable iff (!nrst)
    (duty.eighths == DUTY_NONE && cnt == CW'(PWM_STEP_CYC - 1)) |=> pulse)
    else $error("no-fault duty high part too short");
  a_none_low_part: assert property (@(posedge clk) disable iff (!nrst)
    (duty.eighths == DUTY_NONE && cnt == CW'(PWM_STEP_CYC)) |=> !pulse)
    else $error("no-fault duty high part too long");
  a_full_duty: assert property (@(posedge clk) disable iff (!nrst)
    (duty.eighths == DUTY_LOGIC) |=> pulse)
    else $error("logic supply fault not at full duty");
endmodule
`default_nettype wire

// ===== rtl/bfs_supervisor.sv
// per-channel bridge fault supervisor, top level
// Functional notes
// - bootstrap low flags a fault, masked while the bridge is coasting
// - each rise of bridge-off pin starts refresh timer, both low gates on
// - any conducting transistor with drain-source above threshold is a fault
// - comparator results ignored for a mask time after each turn-on
// - threshold pin at logic rail disables drain-source detection
// - motor supply low reports fault, turns gates off, no latch
// - motor supply high beyond 400 ms reports fault, turns gates off
// - fault pin is a continuous 625 kHz duty-coded signal
// - duty 12.5 none, 25 drain-source or safety, 50 supply class
// - duty 62.5 pin check, 75 overcurrent, 87.5 thermal, 100 logic supply
// - drain-source and pump-rail faults latch until enable low; pump stops on pump-rail or logic supply fault
// - bootstrap low does not latch, pump runs, both low gates on
// - every bridge-off fault turns all four transistors off
// - pin check error reports safety fault at 25 percent duty
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bfs_supervisor import bfs_pkg::*; #(
  parameter int REFRESH_CYCLES = REFRESH_CYC,
  parameter int OV_CYCLES      = OV_CYC,
  parameter int MASK_CYCLES    = MASK_CYC
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // host control pins
  input  wire logic              enable,
  input  wire logic              bridge_off_n,
  input  wire logic [3:0]        fet_cmd,
  // comparator indications
  input  wire logic [3:0]        ds_over,
  input  wire logic              drain_source_threshold_at_rail,
  input  wire logic              bootstrap_cap_low,
  input  wire logic              motor_supply_low,
  input  wire logic              motor_supply_high,
  input  wire logic              gate_pump_rail_low,
  input  wire logic              sense_amp_out_high,
  input  wire logic              thermal_hot,
  input  wire logic              logic_supply_low,
  input  wire logic              pin_check_busy,
  input  wire logic              pin_check_error,
  // gate drivers and pump
  output logic                   high_gate_a,
  output logic                   low_gate_a,
  output logic                   high_gate_b,
  output logic                   low_gate_b,
  output logic                   pump_run,
  // fault pin and interrupt
  output logic                   fault_class_out,
  output logic                   irq,
  // register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wr_data,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [31:0]            rd_data
);
  localparam int RW = $clog2(REFRESH_CYCLES + 1);
  localparam int OW = $clog2(OV_CYCLES + 1);
  localparam int MW = $clog2(MASK_CYCLES + 1);

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ****************************************
  // input synchronisation
  // ****************************************
  logic [19:0] raw_in;
  logic [19:0] sync_in;
  logic        en_s, coast_s, vds_off_s, boot_s, mot_lo_s, mot_hi_s;
  logic        pump_lo_s, oc_s, therm_s, logic_lo_s, pin_busy_s, pin_err_s;
  logic [3:0]  cmd_s, ds_s;

  assign raw_in = {pin_check_error, pin_check_busy, logic_supply_low, thermal_hot,
                   sense_amp_out_high, gate_pump_rail_low, motor_supply_high,
                   motor_supply_low, bootstrap_cap_low, drain_source_threshold_at_rail,
                   ds_over, fet_cmd, bridge_off_n, enable};

  bfs_sync2 #(.W(20)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    (raw_in),
    .q    (sync_in)
  );

  assign {pin_err_s, pin_busy_s, logic_lo_s, therm_s, oc_s, pump_lo_s, mot_hi_s,
          mot_lo_s, boot_s, vds_off_s, ds_s, cmd_s, coast_s, en_s} = sync_in;

  // ****************************************
  // bootstrap refresh timer
  // ****************************************
  bfs_refresh_t   rf_st;
  logic [RW-1:0]  rf_cnt;
  logic           coast_q;
  logic           coast_rise;
  logic           boot_fault;
  logic [1:0]     sync_ok;

  assign coast_rise = coast_s & ~coast_q;
  assign boot_fault = boot_s & coast_s;

  // sync flops clear to zero: holding the idle level stops a false edge at reset release
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync_ok <= 2'b00;
      coast_q <= 1'b1;
    end else begin
      sync_ok <= {sync_ok[0], 1'b1};
      coast_q <= sync_ok[1] ? coast_s : 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rf_st  <= RF_IDLE;
      rf_cnt <= '0;
    end else if (!coast_s) begin
      rf_st <= RF_IDLE;
    end else if (coast_rise) begin
      rf_st  <= RF_ACTIVE;
      rf_cnt <= RW'(REFRESH_CYCLES - 1);
    end else begin
      case (rf_st)
        RF_ACTIVE: begin
          if (rf_cnt == '0) begin
            rf_st <= RF_IDLE;
          end else begin
            rf_cnt <= rf_cnt - 1'b1;
          end
        end
        default: rf_st <= RF_IDLE;
      endcase
    end
  end

  // ****************************************
  // drain-source supervision
  // ****************************************
  logic [3:0]    gate;
  logic [3:0]    ds_hit;
  logic [MW-1:0] mcnt [4];

  for (genvar i = 0; i < 4; i++) begin : g_blank
    always_ff @(posedge clk) begin
      if (!nrst) begin
        mcnt[i] <= '0;
      end else if (!gate[i]) begin
        mcnt[i] <= '0;
      end else if (mcnt[i] != MW'(MASK_CYCLES)) begin
        mcnt[i] <= mcnt[i] + 1'b1;
      end
    end
    assign ds_hit[i] = gate[i] & (mcnt[i] == MW'(MASK_CYCLES)) & ds_s[i] & ~vds_off_s;
  end

  // ****************************************
  // latched and timed faults
  // ****************************************
  logic          ds_lat, pump_lat, ov_fault;
  logic [OW-1:0] ov_cnt;

  // set wins over the enable-low clear so a fault in that cycle is kept
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ds_lat <= 1'b0;
    end else if (|ds_hit) begin
      ds_lat <= 1'b1;
    end else if (!en_s) begin
      ds_lat <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pump_lat <= 1'b0;
    end else if (pump_lo_s) begin
      pump_lat <= 1'b1;
    end else if (!en_s) begin
      pump_lat <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || !mot_hi_s) begin
      ov_cnt   <= '0;
      ov_fault <= 1'b0;
    end else if (ov_cnt == OW'(OV_CYCLES)) begin
      ov_fault <= 1'b1;
    end else begin
      ov_cnt <= ov_cnt + 1'b1;
    end
  end

  // ****************************************
  // bridge and pump control
  // ****************************************
  logic       bridge_off;
  logic       force_low;
  logic [3:0] next_gate;

  assign bridge_off = ~en_s | ~coast_s | ds_lat | pump_lat | mot_lo_s | ov_fault
                    | therm_s | logic_lo_s;
  assign force_low  = (rf_st == RF_ACTIVE) | boot_fault;

  always_comb begin
    if (bridge_off) begin
      next_gate = 4'h0;
    end else if (force_low) begin
      next_gate = LOWS_ONLY;
    end else begin
      next_gate = cmd_s;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      gate     <= 4'h0;
      pump_run <= 1'b0;
    end else begin
      gate     <= next_gate;
      pump_run <= ~(pump_lat | logic_lo_s);
    end
  end

  assign high_gate_a = gate[G_HA];
  assign low_gate_a  = gate[G_LA];
  assign high_gate_b = gate[G_HB];
  assign low_gate_b  = gate[G_LB];

  // ****************************************
  // fault class
  // ****************************************
  bfs_duty_if  duty_if ();
  logic [3:0]  next_duty;
  logic        supply_cls;

  assign supply_cls = ov_fault | mot_lo_s | pump_lat | boot_fault;

  always_comb begin
    if (logic_lo_s) begin
      next_duty = DUTY_LOGIC;
    end else if (therm_s) begin
      next_duty = DUTY_THERM;
    end else if (oc_s) begin
      next_duty = DUTY_OC;
    end else if (pin_busy_s) begin
      next_duty = DUTY_PINCHK;
    end else if (supply_cls) begin
      next_duty = DUTY_SUPPLY;
    end else if (ds_lat | pin_err_s) begin
      next_duty = DUTY_DS;
    end else begin
      next_duty = DUTY_NONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      duty_if.eighths <= DUTY_NONE;
    end else begin
      duty_if.eighths <= next_duty;
    end
  end

  bfs_duty_pwm u_pwm (
    .clk   (clk),
    .nrst  (nrst),
    .duty  (duty_if.pwm),
    .pulse (fault_class_out)
  );

  // ****************************************
  // events, interrupt and registers
  // ****************************************
  logic [EV_W-1:0] ev, ev_q, status, irq_en, clr_mask;

  assign ev = {pin_err_s, logic_lo_s, therm_s, oc_s, boot_fault, ov_fault, mot_lo_s,
               pump_lat, ds_lat};
  assign clr_mask = (wr && hit(addr, REG_IRQ_CLR)) ? wr_data[EV_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ev_q   <= '0;
      status <= '0;
    end else begin
      ev_q   <= ev;
      status <= (status & ~clr_mask) | (ev & ~ev_q);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_en <= IRQ_EN_RST;
    end else if (wr && hit(addr, REG_IRQ_EN)) begin
      irq_en <= wr_data[EV_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & irq_en);
    end
  end

  // unmapped and write-only addresses read as zero
  always_ff @(posedge clk) begin
    if (!nrst || !rd) begin
      rd_data <= '0;
    end else if (hit(addr, REG_STATUS)) begin
      rd_data <= {23'h000000, status};
    end else if (hit(addr, REG_IRQ_EN)) begin
      rd_data <= {23'h000000, irq_en};
    end else if (hit(addr, REG_LIVE)) begin
      rd_data <= {12'h000, duty_if.eighths, 7'h00, ev};
    end else begin
      rd_data <= '0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_fet_on;
    $rose(gate[G_HA]);
  endsequence
  sequence s_masked_window;
    !ds_hit[G_HA] [*4];
  endsequence

  a_boot_masked: assert property (@(posedge clk) disable iff (!nrst)
    !coast_s |-> !boot_fault && !ev[EV_BOOT])
    else $error("bootstrap fault seen while coasting");
  a_refresh_start: assert property (@(posedge clk) disable iff (!nrst)
    coast_rise |=> rf_st == RF_ACTIVE ##1 ((low_gate_a && low_gate_b) || $past(bridge_off)))
    else $error("refresh did not drive low gates");
  a_ds_blanking: assert property (@(posedge clk) disable iff (!nrst)
    s_fet_on |-> s_masked_window)
    else $error("drain-source result used inside mask time");
  a_ds_disabled: assert property (@(posedge clk) disable iff (!nrst)
    vds_off_s |-> ds_hit == 4'h0)
    else $error("drain-source detection not disabled");
  a_ov_needs_time: assert property (@(posedge clk) disable iff (!nrst)
    !mot_hi_s |=> !ov_fault ##1 !ov_fault)
    else $error("overvoltage fault without sustained high supply");
  a_ds_latch_hold: assert property (@(posedge clk) disable iff (!nrst)
    ds_lat && en_s |=> ds_lat && gate == 4'h0)
    else $error("drain-source latch lost or bridge not off");
  a_off_faults: assert property (@(posedge clk) disable iff (!nrst)
    (mot_lo_s || therm_s || logic_lo_s || !coast_s) |=> gate == 4'h0)
    else $error("bridge not off for a bridge-off fault");
  a_pump_stop: assert property (@(posedge clk) disable iff (!nrst)
    (logic_lo_s || pump_lat) |=> !pump_run)
    else $error("pump still running on rail or logic fault");
  a_user_oc: assert property (@(posedge clk) disable iff (!nrst)
    (oc_s && !bridge_off && !force_low) |=> gate == $past(cmd_s) && duty_if.eighths == DUTY_OC)
    else $error("overcurrent changed bridge or duty");
  a_no_fault_duty: assert property (@(posedge clk) disable iff (!nrst)
    (ev == '0 && !pin_busy_s) |=> duty_if.eighths == DUTY_NONE)
    else $error("duty not back to none");
endmodule
`default_nettype wire

// ===== sim/bfs_host_model.sv
// host controller model: drives the control pins and reads the fault pin
`timescale 1ns/1ps
`default_nettype none
module bfs_host_model import bfs_pkg::*; #(
  parameter int REFRESH_CYCLES = 50
) (
  // clock
  input  wire logic clk,
  // control pins
  output logic      enable,
  output logic      bridge_off_n,
  // fault pin
  input  wire logic fault_in
);
  initial begin
    enable       = 1'b1;
    bridge_off_n = 1'b1;
  end

  // ****************************************
  // control pin tasks
  // ****************************************
  task automatic coast(input logic v);
    @(posedge clk);
    bridge_off_n <= v;
  endtask

  // low then high, then wait out the refresh before using the bridge again
  task automatic refresh();
    coast(1'b0);
    repeat (4) @(posedge clk);
    bridge_off_n <= 1'b1;
    repeat (REFRESH_CYCLES + 10) @(posedge clk);
  endtask

  // low pulse on enable releases latched faults
  task automatic en_pulse();
    @(posedge clk);
    enable <= 1'b0;
    repeat (4) @(posedge clk);
    enable <= 1'b1;
    repeat (5) @(posedge clk);
  endtask

  // ****************************************
  // fault pin reader
  // ****************************************
  // high time over one whole period; phase free since the pin repeats
  task automatic read_duty(output logic [3:0] d);
    int hi;
    hi = 0;
    repeat (2 * PWM_PERIOD_CYC) @(posedge clk);
    repeat (PWM_PERIOD_CYC) begin
      @(posedge clk);
      if (fault_in === 1'b1) hi++;
    end
    d = 4'(hi / PWM_STEP_CYC);
  endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench of the bridge fault supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module testbench import bfs_pkg::*;;
  // short counts keep the run brief
  localparam int REF = 50;
  localparam int OVC = 100;
  localparam int MSK = 20;
  logic        clk, nrst, enable, bridge_off_n, thr_rail, mot_hi, pump_low;
  logic [3:0]  fet_cmd, ds_over, duty;
  logic [6:0]  faults;
  logic [7:0]  addr;
  logic [31:0] wr_data, rd_data, seed;
  logic        wr, rd, irq, pump_run, fault_pin, hga, lga, hgb, lgb;
  int          n_errors, n_tests;
  wire  [3:0]  gates = {lgb, hgb, lga, hga};
  // duty of each level fault: supply low, bootstrap, overcurrent, thermal,
  // logic supply, pin check busy, pin check error
  localparam logic [3:0] FDUTY [7] = '{DUTY_SUPPLY, DUTY_SUPPLY, DUTY_OC, DUTY_THERM,
                                       DUTY_LOGIC, DUTY_PINCHK, DUTY_DS};

  // ****************************************
  // expectations
  // ****************************************
  function automatic logic [3:0] exp_duty(input logic [6:0] f);
    exp_duty = DUTY_NONE;
    for (int i = 0; i < 7; i++)
      if (f[i] && FDUTY[i] > exp_duty) exp_duty = FDUTY[i];
  endfunction
  function automatic logic [3:0] exp_gates(input logic [6:0] f, input logic [3:0] cmd);
    if (f[0] || f[3] || f[4]) exp_gates = 4'h0;
    else if (f[1]) exp_gates = LOWS_ONLY;
    else exp_gates = cmd;
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // ****************************************
  // clock, design and host
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  bfs_supervisor #(.REFRESH_CYCLES(REF), .OV_CYCLES(OVC), .MASK_CYCLES(MSK)) dut (
    .clk(clk), .nrst(nrst), .enable(enable), .bridge_off_n(bridge_off_n),
    .fet_cmd(fet_cmd), .ds_over(ds_over), .drain_source_threshold_at_rail(thr_rail),
    .bootstrap_cap_low(faults[1]), .motor_supply_low(faults[0]), .motor_supply_high(mot_hi),
    .gate_pump_rail_low(pump_low), .sense_amp_out_high(faults[2]), .thermal_hot(faults[3]),
    .logic_supply_low(faults[4]), .pin_check_busy(faults[5]), .pin_check_error(faults[6]),
    .high_gate_a(hga), .low_gate_a(lga), .high_gate_b(hgb), .low_gate_b(lgb),
    .pump_run(pump_run), .fault_class_out(fault_pin), .irq(irq), .addr(addr),
    .wr_data(wr_data), .wr(wr), .rd(rd), .rd_data(rd_data));
  bfs_host_model #(.REFRESH_CYCLES(REF)) host (.clk(clk), .enable(enable),
    .bridge_off_n(bridge_off_n), .fault_in(fault_pin));

  // ****************************************
  // bench tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input string m);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rd_data, e, m)
  endtask
  task automatic chk_duty(input logic [3:0] e, input string m);
    host.read_duty(duty);
    `CHK(duty, e, m)
  endtask
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {nrst, fet_cmd, ds_over, thr_rail, faults, mot_hi, pump_low} = '0;
    {addr, wr_data, wr, rd, n_errors, n_tests} = '0;
    seed = 32'hD1588B26;
    tick(4);
    nrst <= 1'b1;
    chk_duty(DUTY_NONE, "idle duty");
    for (int i = 0; i < 7; i++) begin
      faults <= 7'(1 << i);
      fet_cmd <= 4'h9;
      chk_duty(FDUTY[i], "single fault duty");
      if (i < 5) begin
        `CHK(gates, exp_gates(faults, fet_cmd), "single fault gates")
        `CHK(pump_run, !faults[4], "pump run")
      end
    end
    // random mixes of unlatched faults and gate requests
    for (int k = 0; k < 8; k++) begin
      repeat (7) seed = lfsr(seed);
      faults <= {2'b00, seed[4:0]};
      fet_cmd <= seed[11:8];
      chk_duty(exp_duty({2'b00, seed[4:0]}), "combined duty");
      `CHK(gates, exp_gates(faults, fet_cmd), "combined gates")
    end
    faults <= 7'h00;
    chk_duty(DUTY_NONE, "duty after causes clear");
    host.coast(1'b0);
    faults <= 7'h02;
    chk_duty(DUTY_NONE, "bootstrap masked in coast");
    `CHK(gates, 4'h0, "coast gates")
    faults <= 7'h00;
    fet_cmd <= 4'h5;
    fork
      host.refresh();
      begin
        tick(12);
        `CHK(gates, LOWS_ONLY, "refresh low gates")
      end
    join
    `CHK(gates, 4'h5, "gates after refresh")
    fet_cmd <= 4'h1;
    thr_rail <= 1'b1;
    tick(MSK + 10);
    ds_over <= 4'h1;
    tick(20);
    `CHK(gates, 4'h1, "detection off at rail")
    thr_rail <= 1'b0;
    tick(10);
    `CHK(gates, 4'h0, "drain-source fault gates")
    ds_over <= 4'h0;
    chk_duty(DUTY_DS, "drain-source fault latched");
    host.en_pulse();
    `CHK(gates, 4'h1, "gates after enable pulse")
    fet_cmd <= 4'h5;
    tick(1);
    ds_over <= 4'h4;
    tick(MSK / 2);
    ds_over <= 4'h0;
    tick(10);
    `CHK(gates, 4'h5, "comparator masked after turn-on")
    pump_low <= 1'b1;
    tick(10);
    `CHK({pump_run, gates}, 5'h00, "pump rail fault")
    pump_low <= 1'b0;
    chk_duty(DUTY_SUPPLY, "pump rail latched");
    host.en_pulse();
    `CHK({pump_run, gates}, 5'h15, "pump rail cleared")
    mot_hi <= 1'b1;
    tick(OVC / 2);
    `CHK(gates, 4'h5, "short overvoltage ignored")
    mot_hi <= 1'b0;
    tick(5);
    mot_hi <= 1'b1;
    tick(OVC + 10);
    `CHK(gates, 4'h0, "overvoltage turns bridge off")
    chk_duty(DUTY_SUPPLY, "overvoltage duty");
    mot_hi <= 1'b0;
    // registers and interrupt
    wr_reg(REG_IRQ_CLR, 32'h1FF);
    rd_reg(REG_STATUS, 32'h0, "status cleared");
    wr_reg(REG_IRQ_EN, 32'h4);
    rd_reg(REG_IRQ_EN, 32'h4, "irq enable readback");
    rd_reg(8'h10, 32'h0, "unmapped read");
    rd_reg(REG_IRQ_CLR, 32'h0, "clear register reads zero");
    `CHK(irq, 1'b0, "irq idle")
    @(posedge clk);
    faults <= 7'h01;
    tick(6);
    `CHK(irq, 1'b1, "irq raised")
    rd_reg(REG_LIVE, {12'h0, DUTY_SUPPLY, 16'h0004}, "live view");
    @(posedge clk);
    faults <= 7'h00;
    wr_reg(REG_STATUS, 32'h0);
    rd_reg(REG_STATUS, 32'h4, "status sticky and read-only");
    wr_reg(REG_IRQ_EN, 32'h0);
    tick(3);
    `CHK(irq, 1'b0, "irq masked")
    wr_reg(REG_IRQ_EN, 32'h4);
    tick(3);
    `CHK(irq, 1'b1, "irq unmasked")
    wr_reg(REG_IRQ_CLR, 32'h4);
    tick(3);
    `CHK(irq, 1'b0, "irq cleared")
    end_sim();
  end

  // hang guard, well beyond the scenario length
  initial begin
    #(5.0 * 80000);
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
